// file: pkg/timer16_irq_pkg.sv
// constants and types shared by the 16-bit timer capture and interrupt flag block
package timer16_irq_pkg;
    localparam logic [7:0] ADDR_MASK      = 8'h00;
    localparam logic [7:0] ADDR_FLAGS     = 8'h04;
    localparam logic [7:0] ADDR_CTRL      = 8'h08;
    localparam logic [7:0] ADDR_CMP_A_LO  = 8'h0C;
    localparam logic [7:0] ADDR_CMP_A_HI  = 8'h10;
    localparam logic [7:0] ADDR_CMP_B_LO  = 8'h14;
    localparam logic [7:0] ADDR_CMP_B_HI  = 8'h18;
    localparam logic [7:0] ADDR_CAPT_LO   = 8'h1C;
    localparam logic [7:0] ADDR_CAPT_HI   = 8'h20;
    localparam int BIT_CAPTURE  = 5;
    localparam int BIT_CMP_A    = 4;
    localparam int BIT_CMP_B    = 3;
    localparam int BIT_OVERFLOW = 2;
    localparam int BIT_FORCE_A  = 8;
    localparam int BIT_FORCE_B  = 9;
    localparam int BIT_FILTER   = 7;
    localparam int BIT_EDGE     = 6;
    localparam int BIT_ANA_SEL  = 5;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] IMPL_BITS   = 8'h3C;
    localparam int FILTER_SAMPLES = 4;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    typedef enum logic [1:0] {OVF_AT_MAX, OVF_AT_BOTTOM, OVF_AT_TOP} ovf_point_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        tick;
        logic        at_top;
        logic        at_bottom;
        logic [15:0] value;
    } counter_in_t;
endpackage

// file: verilog/timer16_capture_irq_flags.sv
// input capture, compare and overflow flags of a 16-bit timer, Wishbone slave
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
module timer16_capture_irq_flags
    import timer16_irq_pkg::*;
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire timer16_irq_pkg::wb_req_t    wb_i,
    output logic                             wb_ack_o,
    output logic [31:0]                      wb_dat_o,
    input  wire timer16_irq_pkg::counter_in_t cnt_i,
    input  wire logic                        capture_input_pin_i,
    input  wire logic                        comparator_out_i,
    input  wire logic                        global_irq_enable_i,
    input  wire logic [3:0]                  vector_done_i,
    output logic [3:0]                       irq_request_o,
    output logic                             irq_o,
    output logic                             force_compare_a_strobe_o,
    output logic                             force_compare_b_strobe_o,
    output logic [3:0]                       waveform_mode_select_o,
    output logic [15:0]                      compare_a_register_o,
    output logic [15:0]                      compare_b_register_o
);
    import timer16_irq_pkg::*;

    typedef struct packed {
        logic [1:0][2:0] sync;
        logic [1:0]      level;
        logic [3:0]      hist;
        logic            filtered;
        logic            filt_prev;
        logic [7:0]      mask;
        logic [7:0]      flags;
        logic [3:0]      wgm;
        logic            edge_rise;
        logic            filter_en;
        logic            ana_sel;
        logic [15:0]     cmp_a;
        logic [15:0]     cmp_b;
        logic [15:0]     capture;
        logic [7:0]      temp;
        logic            match_a;
        logic            match_b;
        logic            ack;
        logic [7:0]      dat;
        logic [3:0]      irq_req;
        logic            irq;
        logic            force_a;
        logic            force_b;
    } state_t;

    state_t s_reg;
    state_t s_next;

    // pin-side inputs: three flip-flops, stage 0 feeds only stage 1
    logic [1:0] raw_in;
    assign raw_in = {comparator_out_i, capture_input_pin_i};

    logic       req;
    logic       wr;
    logic       rd;
    logic       icr_top;
    logic       cap_src;
    logic       cap_event;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    ovf_point_t ovf_point;
    logic       ovf_hit;

    always_comb
    begin
        unique case (s_reg.wgm)
            4'd0, 4'd4, 4'd12:                        ovf_point = OVF_AT_MAX;
            4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11: ovf_point = OVF_AT_BOTTOM;
            default:                                  ovf_point = OVF_AT_TOP;
        endcase
    end

    always_comb
    begin
        s_next    = s_reg;
        req       = wb_i.cyc && wb_i.stb && !s_reg.ack;
        wr        = req && wb_i.we && wb_i.sel[0];
        rd        = req && !wb_i.we;
        // modes that take the capture register as top
        icr_top   = (s_reg.wgm == 4'd8) || (s_reg.wgm == 4'd10) || (s_reg.wgm == 4'd12) || (s_reg.wgm == 4'd14);
        set_bits  = 8'h00;
        clr_bits  = 8'h00;

        for (int i = 0; i < 2; i++)
        begin
            s_next.sync[i] = {s_reg.sync[i][1:0], raw_in[i]};
            if (s_reg.sync[i][1] == s_reg.sync[i][2])
                s_next.level[i] = s_reg.sync[i][2];
        end

        cap_src = s_reg.ana_sel ? s_reg.level[1] : s_reg.level[0];
        s_next.hist = {s_reg.hist[2:0], cap_src};
        if (!s_reg.filter_en)
            s_next.filtered = cap_src;
        else if (&{s_reg.hist, cap_src} || !(|{s_reg.hist, cap_src}))
            s_next.filtered = cap_src;
        s_next.filt_prev = s_reg.filtered;

        cap_event = !icr_top && (s_reg.edge_rise ? (s_reg.filtered && !s_reg.filt_prev)
                                                 : (!s_reg.filtered && s_reg.filt_prev));
        if (cap_event)
            s_next.capture = cnt_i.value;
        if (cap_event || (icr_top && cnt_i.tick && cnt_i.at_top))
            set_bits[BIT_CAPTURE] = 1'b1;

        // compare match is registered on one tick and flagged on the next
        if (cnt_i.tick)
        begin
            s_next.match_a = (cnt_i.value == s_reg.cmp_a);
            s_next.match_b = (cnt_i.value == s_reg.cmp_b);
        end
        set_bits[BIT_CMP_A] = cnt_i.tick && s_reg.match_a;
        set_bits[BIT_CMP_B] = cnt_i.tick && s_reg.match_b;

        unique case (ovf_point)
            OVF_AT_MAX:    ovf_hit = (cnt_i.value == COUNT_MAX);
            OVF_AT_BOTTOM: ovf_hit = cnt_i.at_bottom;
            OVF_AT_TOP:    ovf_hit = cnt_i.at_top;
        endcase
        set_bits[BIT_OVERFLOW] = cnt_i.tick && ovf_hit;

        clr_bits[BIT_CAPTURE]  = vector_done_i[3];
        clr_bits[BIT_CMP_A]    = vector_done_i[2];
        clr_bits[BIT_CMP_B]    = vector_done_i[1];
        clr_bits[BIT_OVERFLOW] = vector_done_i[0];

        s_next.force_a = 1'b0;
        s_next.force_b = 1'b0;
        s_next.ack     = req;
        s_next.dat     = 8'h00;

        if (wr)
        begin
            unique case (wb_i.adr)
                ADDR_MASK:  s_next.mask = wb_i.dat[7:0] & IMPL_BITS;
                ADDR_FLAGS: clr_bits = clr_bits | (wb_i.dat[7:0] & IMPL_BITS);
                ADDR_CTRL:
                begin
                    s_next.wgm       = wb_i.dat[3:0];
                    s_next.ana_sel   = wb_i.dat[BIT_ANA_SEL];
                    s_next.edge_rise = wb_i.dat[BIT_EDGE];
                    s_next.filter_en = wb_i.dat[BIT_FILTER];
                    // force strobes act only when the written mode has both low bits clear (modes 0, 4, 8, 12)
                    s_next.force_a   = wb_i.dat[BIT_FORCE_A] && wb_i.sel[1] && (wb_i.dat[1:0] == 2'b00);
                    s_next.force_b   = wb_i.dat[BIT_FORCE_B] && wb_i.sel[1] && (wb_i.dat[1:0] == 2'b00);
                end
                ADDR_CMP_A_HI, ADDR_CMP_B_HI, ADDR_CAPT_HI: s_next.temp = wb_i.dat[7:0];
                ADDR_CMP_A_LO: s_next.cmp_a = {s_reg.temp, wb_i.dat[7:0]};
                ADDR_CMP_B_LO: s_next.cmp_b = {s_reg.temp, wb_i.dat[7:0]};
                ADDR_CAPT_LO:  if (icr_top) s_next.capture = {s_reg.temp, wb_i.dat[7:0]};
                default: ;
            endcase
        end

        if (rd)
        begin
            unique case (wb_i.adr)
                ADDR_MASK:  s_next.dat = s_reg.mask;
                ADDR_FLAGS: s_next.dat = s_reg.flags;
                ADDR_CTRL:  s_next.dat = {s_reg.filter_en, s_reg.edge_rise, s_reg.ana_sel, 1'b0, s_reg.wgm};
                ADDR_CMP_A_LO: s_next.dat = s_reg.cmp_a[7:0];
                ADDR_CMP_B_LO: s_next.dat = s_reg.cmp_b[7:0];
                ADDR_CAPT_LO:
                begin
                    s_next.dat  = s_reg.capture[7:0];
                    s_next.temp = s_reg.capture[15:8];
                end
                ADDR_CMP_A_HI, ADDR_CMP_B_HI, ADDR_CAPT_HI: s_next.dat = s_reg.temp;
                default: s_next.dat = 8'h00;
            endcase
        end

        // hardware set wins over a clear in the same cycle
        s_next.flags = ((s_reg.flags & ~clr_bits) | set_bits) & IMPL_BITS;

        s_next.irq_req[3] = s_reg.mask[BIT_CAPTURE]  && s_reg.flags[BIT_CAPTURE]  && global_irq_enable_i;
        s_next.irq_req[2] = s_reg.mask[BIT_CMP_A]    && s_reg.flags[BIT_CMP_A]    && global_irq_enable_i;
        s_next.irq_req[1] = s_reg.mask[BIT_CMP_B]    && s_reg.flags[BIT_CMP_B]    && global_irq_enable_i;
        s_next.irq_req[0] = s_reg.mask[BIT_OVERFLOW] && s_reg.flags[BIT_OVERFLOW] && global_irq_enable_i;
        s_next.irq        = |(s_reg.mask & s_reg.flags);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg       <= '0;
            s_reg.mask  <= MASK_RESET;
            s_reg.flags <= FLAGS_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o                 = s_reg.ack;
    assign wb_dat_o                 = {24'h000000, s_reg.dat};
    assign irq_request_o            = s_reg.irq_req;
    assign irq_o                    = s_reg.irq;
    assign force_compare_a_strobe_o = s_reg.force_a;
    assign force_compare_b_strobe_o = s_reg.force_b;
    assign waveform_mode_select_o   = s_reg.wgm;
    assign compare_a_register_o     = s_reg.cmp_a;
    assign compare_b_register_o     = s_reg.cmp_b;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence match_a_seen;
        cnt_i.tick && (cnt_i.value == s_reg.cmp_a);
    endsequence
    sequence match_b_seen;
        cnt_i.tick && (cnt_i.value == s_reg.cmp_b);
    endsequence
    sequence bus_take;
        wb_i.cyc && wb_i.stb && !s_reg.ack;
    endsequence
    sequence ovf_seen;
        cnt_i.tick && ovf_hit;
    endsequence
    sequence rise_seen;
        s_reg.filtered && !s_reg.filt_prev;
    endsequence
    sequence top_seen;
        icr_top && cnt_i.tick && cnt_i.at_top;
    endsequence

    AST_CAPTURE_LOAD: assert property (cap_event |=> s_reg.capture == $past(cnt_i.value))
        else $error("capture register missed counter value");
    AST_TEMP_LATCH: assert property (rd && wb_i.adr == ADDR_CAPT_LO |=> s_reg.temp == $past(s_reg.capture[15:8]))
        else $error("temp not loaded by capture low read");
    AST_IRQ_CAPTURE: assert property (irq_request_o[3] |-> $past(s_reg.mask[5] && s_reg.flags[5] && global_irq_enable_i))
        else $error("capture request without cause");
    AST_IRQ_CMP_A: assert property (irq_request_o[2] == $past(s_reg.mask[4] && s_reg.flags[4] && global_irq_enable_i))
        else $error("compare A request wrong");
    AST_IRQ_CMP_B: assert property (!global_irq_enable_i |=> !irq_request_o[1])
        else $error("compare B request with global off");
    AST_IRQ_OVF: assert property (!s_reg.mask[2] |=> !irq_request_o[0])
        else $error("overflow request while disabled");
    AST_UNUSED_BIT: assert property (!s_reg.mask[1] && !s_reg.flags[1])
        else $error("unused bit set");
    AST_CAP_FLAG: assert property (cap_event |=> s_reg.flags[BIT_CAPTURE])
        else $error("capture flag not set");
    AST_CMP_A_NEXT: assert property (match_a_seen ##1 cnt_i.tick |=> s_reg.flags[BIT_CMP_A])
        else $error("compare A flag not set on following tick");
    AST_CMP_B_NEXT: assert property (match_b_seen ##1 cnt_i.tick |=> s_reg.flags[BIT_CMP_B])
        else $error("compare B flag not set on following tick");
    AST_FORCE_A: assert property (force_compare_a_strobe_o && !s_reg.match_a && !$past(s_reg.flags[4])
                                  |-> !s_reg.flags[BIT_CMP_A] || $past(s_reg.match_a))
        else $error("force strobe set compare A flag");
    AST_CLEAR: assert property (vector_done_i[0] && !(cnt_i.tick && ovf_hit) |=> !s_reg.flags[BIT_OVERFLOW])
        else $error("overflow flag not cleared by vector");
    AST_SET_WINS: assert property (set_bits[BIT_CAPTURE] && clr_bits[BIT_CAPTURE] |=> s_reg.flags[BIT_CAPTURE])
        else $error("clear beat set");
    AST_TOP_DISC: assert property (icr_top |-> !cap_event)
        else $error("capture while capture register is top");

    // bus handshake: one ack per take, data only alongside ack
    AST_ACK_ONE: assert property (bus_take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse");
    AST_NO_ACK: assert property (!(wb_i.cyc && wb_i.stb) |=> !wb_ack_o)
        else $error("ack without request");
    AST_DAT_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data outside ack");

    // register loads through the shared high-byte latch
    AST_CMP_A_LOAD: assert property (wr && wb_i.adr == ADDR_CMP_A_LO |=> s_reg.cmp_a == {$past(s_reg.temp), $past(wb_i.dat[7:0])})
        else $error("compare A load wrong");
    AST_CMP_B_LOAD: assert property (wr && wb_i.adr == ADDR_CMP_B_LO |=> s_reg.cmp_b == {$past(s_reg.temp), $past(wb_i.dat[7:0])})
        else $error("compare B load wrong");
    AST_TEMP_HI_WRITE: assert property (wr && wb_i.adr == ADDR_CAPT_HI |=> s_reg.temp == $past(wb_i.dat[7:0]))
        else $error("high byte latch not written");
    AST_CAPT_HOLD: assert property (!cap_event && !(wr && wb_i.adr == ADDR_CAPT_LO) |=> $stable(s_reg.capture))
        else $error("capture register changed without cause");
    AST_MASK_BITS: assert property ((s_reg.mask & ~IMPL_BITS) == 8'h00)
        else $error("unimplemented mask bit set");

    // capture source: edge choice and noise filter
    AST_EDGE_RISE: assert property (s_reg.edge_rise && !icr_top && rise_seen |-> cap_event)
        else $error("rising edge missed");
    AST_EDGE_FALL: assert property (!s_reg.edge_rise && rise_seen |-> !cap_event)
        else $error("rising edge captured in falling mode");
    AST_FILTER_HOLD: assert property (s_reg.filter_en && (s_reg.hist[0] != cap_src) |=> s_reg.filtered == $past(s_reg.filtered))
        else $error("filter output moved on unequal samples");

    // flag set paths
    AST_OVF_SET: assert property (ovf_seen |=> s_reg.flags[BIT_OVERFLOW])
        else $error("overflow flag not set");
    AST_TOP_FLAG: assert property (top_seen |=> s_reg.flags[BIT_CAPTURE])
        else $error("capture flag not set at top");
    AST_FORCE_B: assert property (force_compare_b_strobe_o && !s_reg.match_b && !$past(s_reg.flags[3])
                                  |-> !s_reg.flags[BIT_CMP_B] || $past(s_reg.match_b))
        else $error("force strobe set compare B flag");
    AST_FORCE_CAUSE: assert property (force_compare_a_strobe_o |-> $past(wr && wb_i.adr == ADDR_CTRL))
        else $error("force strobe without control write");

    // flag clear paths; a set in the same cycle is allowed to win
    AST_CLEAR_CMP_A: assert property (vector_done_i[2] && !(cnt_i.tick && s_reg.match_a) |=> !s_reg.flags[BIT_CMP_A])
        else $error("compare A flag not cleared by vector");
    AST_CLEAR_CMP_B: assert property (vector_done_i[1] && !(cnt_i.tick && s_reg.match_b) |=> !s_reg.flags[BIT_CMP_B])
        else $error("compare B flag not cleared by vector");
    AST_CLEAR_CAPT: assert property (vector_done_i[3] && !set_bits[BIT_CAPTURE] |=> !s_reg.flags[BIT_CAPTURE])
        else $error("capture flag not cleared by vector");
    AST_SW_CLEAR: assert property (wr && wb_i.adr == ADDR_FLAGS && wb_i.dat[BIT_OVERFLOW] && !(cnt_i.tick && ovf_hit)
                                   |=> !s_reg.flags[BIT_OVERFLOW])
        else $error("overflow flag not cleared by write");
    AST_ZERO_WRITE: assert property (wr && wb_i.adr == ADDR_FLAGS && wb_i.dat[7:0] == 8'h00 && vector_done_i == 4'h0
                                     |=> (s_reg.flags & $past(s_reg.flags)) == $past(s_reg.flags))
        else $error("zero write cleared a flag");

    // interrupt requests
    AST_IRQ_CMP_B_CAUSE: assert property (irq_request_o[1] |-> $past(s_reg.mask[3] && s_reg.flags[3]))
        else $error("compare B request without cause");
    AST_IRQ_OVF_CAUSE: assert property (irq_request_o[0] |-> $past(s_reg.flags[2] && global_irq_enable_i))
        else $error("overflow request without cause");
    AST_GLOBAL_OFF: assert property (!global_irq_enable_i |=> irq_request_o == 4'h0)
        else $error("request with global flag off");
    AST_IRQ_QUIET: assert property ((s_reg.flags & s_reg.mask) == 8'h00 |=> !irq_o)
        else $error("interrupt line without unmasked flag");
endmodule

// file: verif/counter_pin_model.sv
// counter and capture pin source standing outside the capture and flag block
`timescale 1ns/1ps
module counter_pin_model
    import timer16_irq_pkg::*;
#(
    parameter logic [15:0] TOP_VALUE = 16'h00F8
)
(
    input  wire logic                    clk_i,
    input  wire logic                    run_i,
    input  wire logic                    load_i,
    input  wire logic [15:0]             load_val_i,
    input  wire logic                    pin_i,
    output timer16_irq_pkg::counter_in_t cnt_o,
    output logic                         pin_o
);
    logic [15:0] value_reg = 16'h0000;
    initial pin_o = 1'b0;
    always @(posedge clk_i)
    begin
        if (load_i)
            value_reg <= load_val_i;
        else if (run_i)
            value_reg <= value_reg + 16'h0001;
        pin_o <= pin_i;
    end
    // ticks on every clock while running, the fastest rate the block has to follow
    assign cnt_o = '{tick: run_i, at_top: value_reg == TOP_VALUE, at_bottom: value_reg == 16'h0000,
                     value: value_reg};
endmodule

// file: verif/test_timer16_capture_irq_flags.sv
// self-checking bench for the capture register and interrupt flag block
`timescale 1ns/1ps
module test_timer16_capture_irq_flags;
    import timer16_irq_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    wb_req_t     wb = '0;
    logic        wb_ack_o;
    logic [31:0] wb_dat_o;
    counter_in_t cnt;
    logic        run = 1'b0;
    logic        load = 1'b0;
    logic [15:0] load_val = 16'h0000;
    logic        pin = 1'b0;
    logic        pin_sync;
    logic        glob = 1'b0;
    logic [3:0]  vec = 4'h0;
    logic [3:0]  irq_req;
    logic        irq;
    logic        fa;
    logic        fb;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [3:0]  wgm;
    logic        comp = 1'b0;
    logic [1:0]  seen = 2'b00;
    logic [31:0] rd_tmp;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycle_cnt = 0;

    always #12.5 clk_i = ~clk_i;

    counter_pin_model model (.clk_i(clk_i), .run_i(run), .load_i(load), .load_val_i(load_val),
        .pin_i(pin), .cnt_o(cnt), .pin_o(pin_sync));

    timer16_capture_irq_flags uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .cnt_i(cnt), .capture_input_pin_i(pin_sync), .comparator_out_i(comp),
        .global_irq_enable_i(glob), .vector_done_i(vec), .irq_request_o(irq_req), .irq_o(irq),
        .force_compare_a_strobe_o(fa), .force_compare_b_strobe_o(fb), .waveform_mode_select_o(wgm),
        .compare_a_register_o(cmpa), .compare_b_register_o(cmpb));

    // strobes last one cycle, so they are latched here rather than polled
    always @(posedge clk_i)
    begin
        if (fa === 1'b1) seen[0] <= 1'b1;
        if (fb === 1'b1) seen[1] <= 1'b1;
        cycle_cnt++;
        if (cycle_cnt == 4000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle, entered right after a rising edge; ack and data are taken at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h3, adr: a, dat: d};
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb <= '0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rd_tmp);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] got;
        xfer(1'b0, a, 32'h0, got);
        check(nm, e, got);
    endtask

    task automatic wait_c(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic pulse_vec(input logic [3:0] v);
        vec <= v;
        @(posedge clk_i);
        vec <= 4'h0;
        wait_c(2);
    endtask

    task automatic set_pin(input logic v);
        pin <= v;
        wait_c(14);
    endtask

    initial
    begin
        wait_c(8);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd("mask", ADDR_MASK, 32'h0);
        rd("flags", ADDR_FLAGS, 32'h0);
        wr(ADDR_MASK, 32'hFF);
        rd("mask", ADDR_MASK, {24'h0, IMPL_BITS});
        wr(ADDR_FLAGS, 32'hFF);
        rd("flags", ADDR_FLAGS, 32'h0);
        rd("unmapped", 8'hFC, 32'h0);
        load <= 1'b1;
        load_val <= 16'h1234;
        glob <= 1'b1;
        @(posedge clk_i);
        load <= 1'b0;
        wr(ADDR_CTRL, 32'h40);
        set_pin(1'b1);
        rd("flags", ADDR_FLAGS, 32'h20);
        check("irq_req", 32'h8, {28'h0, irq_req});
        check("irq", 32'h1, {31'h0, irq});
        glob <= 1'b0;
        wait_c(3);
        check("irq_req", 32'h0, {28'h0, irq_req});
        glob <= 1'b1;
        rd("capt_lo", ADDR_CAPT_LO, 32'h34);
        rd("capt_hi", ADDR_CAPT_HI, 32'h12);
        wr(ADDR_FLAGS, 32'h00);
        rd("flags", ADDR_FLAGS, 32'h20);
        pulse_vec(4'h8);
        rd("flags", ADDR_FLAGS, 32'h0);
        set_pin(1'b0);
        rd("flags", ADDR_FLAGS, 32'h0);
        wr(ADDR_CTRL, 32'h00);
        load <= 1'b1;
        load_val <= 16'h5678;
        @(posedge clk_i);
        load <= 1'b0;
        set_pin(1'b1);
        rd("flags", ADDR_FLAGS, 32'h0);
        set_pin(1'b0);
        rd("flags", ADDR_FLAGS, 32'h20);
        rd("capt_lo", ADDR_CAPT_LO, 32'h78);
        wr(ADDR_FLAGS, 32'h20);
        rd("flags", ADDR_FLAGS, 32'h0);
        wr(ADDR_CTRL, 32'hE0);
        rd("ctrl", ADDR_CTRL, 32'hE0);
        comp <= 1'b1;
        wait_c(16);
        rd("flags", ADDR_FLAGS, 32'h20);
        comp <= 1'b0;
        wait_c(16);
        wr(ADDR_FLAGS, 32'h20);
        rd("flags", ADDR_FLAGS, 32'h0);
        wr(ADDR_CTRL, 32'h300);
        wait_c(4);
        check("force", 32'h3, {30'h0, seen});
        rd("flags", ADDR_FLAGS, 32'h0);
        wr(ADDR_CMP_A_HI, 32'hFF);
        wr(ADDR_CMP_A_LO, 32'hF4);
        wr(ADDR_CMP_B_HI, 32'hFF);
        wr(ADDR_CMP_B_LO, 32'hF8);
        check("cmp_a", 32'hFFF4, {16'h0, cmpa});
        check("cmp_b", 32'hFFF8, {16'h0, cmpb});
        load <= 1'b1;
        load_val <= 16'hFFF0;
        @(posedge clk_i);
        load <= 1'b0;
        run <= 1'b1;
        wait_c(30);
        run <= 1'b0;
        rd("flags", ADDR_FLAGS, 32'h1C);
        check("irq_req", 32'h7, {28'h0, irq_req});
        pulse_vec(4'h7);
        rd("flags", ADDR_FLAGS, 32'h0);
        wr(ADDR_CTRL, 32'h0C);
        check("wgm", 32'hC, {28'h0, wgm});
        load <= 1'b1;
        load_val <= 16'h00F0;
        @(posedge clk_i);
        load <= 1'b0;
        set_pin(1'b1);
        set_pin(1'b0);
        rd("flags", ADDR_FLAGS, 32'h0);
        run <= 1'b1;
        wait_c(20);
        run <= 1'b0;
        rd("flags", ADDR_FLAGS, 32'h20);
        final_report();
    end
endmodule
